/* File: tree_index_ctrl.sv */
// Translation control registers and tree index derivation.
//
// The implementer's own choices: the plain strobed port and the address map.
`timescale 1ns/10ps
`include "tree_index_map.svh"
module tree_index_ctrl (
	input wire logic clock, // 25 MHz clock
	input wire logic rst, // synchronous reset, active high
	input wire logic [7:0] reg_addr, // register byte address
	input wire logic [31:0] reg_wdata, // register write data
	input wire logic reg_wr, // write strobe
	input wire logic reg_rd, // read strobe
	output logic [31:0] reg_rdata, // read data, cycle after the strobe
	input wire tree_index_pkg::lookup_req_s lookup_req, // logical access to index
	output tree_index_pkg::lookup_res_s lookup_res, // derived tree indices
	input wire tree_index_pkg::desc_in_s desc_in, // fetched descriptor word
	output tree_index_pkg::desc_out_s desc_out, // indirect descriptor address
	output logic irq // level interrupt
);
	tree_index_pkg::translation_control_s tc_reg, tc_next;
	tree_index_pkg::root_hi_s crp_hi_reg, crp_hi_next, srp_hi_reg, srp_hi_next;
	logic [31:0] crp_lo_reg, crp_lo_next, srp_lo_reg, srp_lo_next;
	logic [`EV_WIDTH-1:0] status_reg, status_next, enable_reg, enable_next, events;
	logic [31:0] rdata_reg, rdata_next;
	tree_index_pkg::lookup_res_s res_reg, res_next;
	tree_index_pkg::desc_out_s desc_reg, desc_next;

	// Pulls a field of the given width starting skip bits below bit 31.
	function automatic tree_index_pkg::index_t index_field(input logic [31:0] addr, input logic [5:0] skip,
			input logic [3:0] width);
		logic [31:0] shifted;
		shifted = addr << skip;
		index_field = width == 4'h0 ? 15'h0000 : 15'(shifted >> (6'h20 - {2'h0, width}));
	endfunction

	function automatic logic [5:0] widen(input logic [3:0] v);
		widen = {2'h0, v};
	endfunction

	// Register file and interrupt status.
	always_comb begin
		tc_next = tc_reg;
		crp_hi_next = crp_hi_reg;
		crp_lo_next = crp_lo_reg;
		srp_hi_next = srp_hi_reg;
		srp_lo_next = srp_lo_reg;
		enable_next = enable_reg;
		events = '0;
		rdata_next = 32'h0000_0000;
		status_next = status_reg;
		if (reg_wr) begin
			unique case (reg_addr)
				`ADDR_TC: tc_next = reg_wdata;
				`ADDR_CRP_HI: begin
					// An invalid type is refused so the walk never starts from a dead root.
					if (reg_wdata[1:0] == `DT_INVALID) begin
						events[`EV_CONFIG] = 1'b1;
					end else begin
						crp_hi_next = reg_wdata;
					end
				end
				`ADDR_CRP_LO: crp_lo_next = reg_wdata;
				`ADDR_SRP_HI: begin
					if (reg_wdata[1:0] == `DT_INVALID) begin
						events[`EV_CONFIG] = 1'b1;
					end else begin
						srp_hi_next = reg_wdata;
					end
				end
				`ADDR_SRP_LO: srp_lo_next = reg_wdata;
				`ADDR_CLEAR: status_next = status_reg & ~reg_wdata[`EV_WIDTH-1:0];
				`ADDR_ENABLE: enable_next = reg_wdata[`EV_WIDTH-1:0];
				default: ;
			endcase
		end
		if (reg_rd) begin
			unique case (reg_addr)
				`ADDR_TC: rdata_next = tc_reg;
				`ADDR_CRP_HI: rdata_next = crp_hi_reg;
				`ADDR_CRP_LO: rdata_next = crp_lo_reg;
				`ADDR_SRP_HI: rdata_next = srp_hi_reg;
				`ADDR_SRP_LO: rdata_next = srp_lo_reg;
				`ADDR_STATUS: rdata_next = {29'h0000_0000, status_reg};
				`ADDR_ENABLE: rdata_next = {29'h0000_0000, enable_reg};
				default: rdata_next = 32'h0000_0000;
			endcase
		end
		events[`EV_LIMIT] = res_next.valid & res_next.limit_fault;
		events[`EV_DONE] = res_next.valid;
		// A new event wins over a clear in the same cycle.
		status_next = status_next | events;
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			tc_reg <= `TC_RESET;
			crp_hi_reg <= `RP_HI_RESET;
			crp_lo_reg <= `RP_LO_RESET;
			srp_hi_reg <= `RP_HI_RESET;
			srp_lo_reg <= `RP_LO_RESET;
			status_reg <= '0;
			enable_reg <= '0;
			rdata_reg <= 32'h0000_0000;
		end else begin
			tc_reg <= tc_next;
			crp_hi_reg <= crp_hi_next;
			crp_lo_reg <= crp_lo_next;
			srp_hi_reg <= srp_hi_next;
			srp_lo_reg <= srp_lo_next;
			status_reg <= status_next;
			enable_reg <= enable_next;
			rdata_reg <= rdata_next;
		end
	end

	// Index derivation for one logical access.
	always_comb begin
		logic [3:0] w_a, w_b, w_c, w_d;
		logic [5:0] skip;
		tree_index_pkg::root_hi_s root;
		w_a = tc_reg.first_level_index_width;
		w_b = w_a != 4'h0 ? tc_reg.second_level_index_width : 4'h0;
		w_c = w_b != 4'h0 ? tc_reg.third_level_index_width : 4'h0;
		w_d = w_c != 4'h0 ? tc_reg.fourth_level_index_width : 4'h0;
		skip = widen(tc_reg.initial_shift);
		res_next = '0;
		res_next.valid = lookup_req.valid;
		res_next.use_supervisor_root = tc_reg.supervisor_root_enable & lookup_req.function_code[2];
		root = res_next.use_supervisor_root ? srp_hi_reg : crp_hi_reg;
		res_next.root_table_address = res_next.use_supervisor_root ? srp_lo_reg : crp_lo_reg;
		res_next.fc_level = tc_reg.function_code_lookup_enable;
		res_next.fc_index = tc_reg.function_code_lookup_enable ? lookup_req.function_code : 3'h0;
		// Each field sits directly below the one above it.
		res_next.level_index[0] = index_field(lookup_req.logical_address, skip, w_a);
		res_next.level_index[1] = index_field(lookup_req.logical_address, skip + widen(w_a), w_b);
		res_next.level_index[2] = index_field(lookup_req.logical_address, skip + widen(w_a) + widen(w_b), w_c);
		res_next.level_index[3] = index_field(lookup_req.logical_address,
			skip + widen(w_a) + widen(w_b) + widen(w_c), w_d);
		res_next.levels = 3'({2'h0, tc_reg.function_code_lookup_enable} + {2'h0, w_a != 4'h0}
			+ {2'h0, w_b != 4'h0} + {2'h0, w_c != 4'h0} + {2'h0, w_d != 4'h0});
		res_next.page_table_level = res_next.levels == 3'h0 ? 3'h0 : res_next.levels - 3'h1;
		res_next.page_offset = lookup_req.logical_address & ((32'h0000_0001 << tc_reg.page_size_field)
			- 32'h0000_0001);
		res_next.pages_log2 = (6'h20 - skip) - widen(tc_reg.page_size_field);
		// The limit is meaningless once the top level is indexed by function code.
		if (!tc_reg.function_code_lookup_enable) begin
			res_next.limit_fault = root.lower_upper ? res_next.level_index[0] < root.limit
				: res_next.level_index[0] > root.limit;
		end
	end

	// Indirect descriptors carry a page descriptor address; unused bits never reach it.
	always_comb begin
		desc_next.valid = desc_in.valid && desc_in.kind != tree_index_pkg::DESC_OTHER;
		desc_next.address = desc_next.valid ? desc_in.word[31:2] : 30'h0000_0000;
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			res_reg <= '0;
			desc_reg <= '0;
		end else begin
			res_reg <= res_next;
			desc_reg <= desc_next;
		end
	end

	assign reg_rdata = rdata_reg;
	assign lookup_res = res_reg;
	assign desc_out = desc_reg;
	assign irq = |(status_reg & enable_reg);

	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	a_root_select_pair: assert property (lookup_req.valid |=> lookup_res.use_supervisor_root ==
			($past(tc_reg.supervisor_root_enable) && $past(lookup_req.function_code[2])))
		else $error("supervisor root chosen without both enable and function code bit 2");
	a_dt_zero_trap: assert property ((reg_wr && reg_addr == `ADDR_SRP_HI && reg_wdata[1:0] == 2'h0)
			|=> status_reg[`EV_CONFIG] && $stable(srp_hi_reg))
		else $error("zero descriptor type load did not trap");
	a_crp_dt_trap: assert property ((reg_wr && reg_addr == `ADDR_CRP_HI && reg_wdata[1:0] == 2'h0)
			|=> status_reg[`EV_CONFIG] && $stable(crp_hi_reg))
		else $error("zero descriptor type load into cpu root did not trap");
	a_level_count_max: assert property (lookup_res.valid |-> lookup_res.levels <= `MAX_LEVELS)
		else $error("more than five tree levels");
	a_fcl_no_limit: assert property (lookup_res.valid && lookup_res.fc_level |-> !lookup_res.limit_fault)
		else $error("limit checked while function code lookup is on");
	a_chain_ends_early: assert property ((lookup_req.valid && !tc_reg.function_code_lookup_enable
			&& tc_reg.first_level_index_width != 4'h0 && tc_reg.second_level_index_width == 4'h0)
			|=> lookup_res.levels == 3'h1 && lookup_res.level_index[1] == 15'h0000)
		else $error("index chain did not stop at the first zero width");
	a_top_index_bits: assert property ((lookup_req.valid && tc_reg.initial_shift == 4'h0
			&& tc_reg.first_level_index_width == 4'h4) |=> lookup_res.level_index[0] ==
			{11'h000, $past(lookup_req.logical_address[31:28])})
		else $error("first index not taken from the top address bits");
	a_indirect_only: assert property (desc_in.valid && desc_in.kind == tree_index_pkg::DESC_OTHER
			|=> !desc_out.valid)
		else $error("descriptor address used for a non-indirect descriptor");
	a_fc_top_index: assert property ((lookup_req.valid && tc_reg.function_code_lookup_enable)
			|=> lookup_res.fc_level && lookup_res.fc_index == $past(lookup_req.function_code))
		else $error("function code level not indexed by the code bits");

	a_tc_write_lands: assert property ((reg_wr && reg_addr == `ADDR_TC)
			|=> tc_reg == $past(reg_wdata))
		else $error("translation control write did not land");

	a_crp_load_lands: assert property ((reg_wr && reg_addr == `ADDR_CRP_HI
			&& reg_wdata[1:0] != `DT_INVALID) |=> crp_hi_reg == $past(reg_wdata))
		else $error("valid cpu root pointer load was lost");

	a_srp_load_lands: assert property ((reg_wr && reg_addr == `ADDR_SRP_HI
			&& reg_wdata[1:0] != `DT_INVALID) |=> srp_hi_reg == $past(reg_wdata))
		else $error("valid supervisor root pointer load was lost");

	a_config_cause: assert property ($rose(status_reg[`EV_CONFIG]) |-> $past(reg_wr)
			&& $past(reg_wdata[1:0]) == `DT_INVALID
			&& ($past(reg_addr) == `ADDR_CRP_HI || $past(reg_addr) == `ADDR_SRP_HI))
		else $error("configuration exception without a zero type root load");

	a_zero_shift_full: assert property ((lookup_req.valid && tc_reg.initial_shift == 4'h0
			&& tc_reg.first_level_index_width != 4'h0) |=> lookup_res.level_index[0]
			== 15'($past(lookup_req.logical_address) >> (6'h20 - {2'h0, $past(tc_reg.first_level_index_width)})))
		else $error("zero initial shift did not use the full address");

	a_offset_in_page: assert property (lookup_req.valid
			|=> (lookup_res.page_offset >> $past(tc_reg.page_size_field)) == 32'h0000_0000)
		else $error("page offset wider than the page size");

	a_offset_from_addr: assert property (lookup_req.valid |=> (lookup_res.page_offset
			| ($past(lookup_req.logical_address) >> $past(tc_reg.page_size_field) << $past(tc_reg.page_size_field)))
			== $past(lookup_req.logical_address))
		else $error("page offset does not match the low address bits");

	a_page_count: assert property (lookup_req.valid |=> lookup_res.pages_log2
			+ {2'h0, $past(tc_reg.page_size_field)} + {2'h0, $past(tc_reg.initial_shift)} == 6'h20)
		else $error("page count does not match space over page size");

	a_fc_off_index: assert property ((lookup_req.valid && !tc_reg.function_code_lookup_enable)
			|=> !lookup_res.fc_level && lookup_res.fc_index == 3'h0)
		else $error("function code level present while lookup is off");

	a_first_width: assert property (lookup_req.valid
			|=> (lookup_res.level_index[0] >> $past(tc_reg.first_level_index_width)) == 15'h0000)
		else $error("first index wider than its field");

	a_second_width: assert property (lookup_req.valid
			|=> (lookup_res.level_index[1] >> $past(tc_reg.second_level_index_width)) == 15'h0000)
		else $error("second index wider than its field");

	a_tic_zero_tail: assert property ((lookup_req.valid && tc_reg.third_level_index_width == 4'h0)
			|=> lookup_res.level_index[2] == 15'h0000 && lookup_res.level_index[3] == 15'h0000)
		else $error("index after a zero width was not ignored");

	a_two_levels: assert property ((lookup_req.valid && !tc_reg.function_code_lookup_enable
			&& tc_reg.first_level_index_width != 4'h0 && tc_reg.second_level_index_width != 4'h0
			&& tc_reg.third_level_index_width == 4'h0) |=> lookup_res.levels == 3'h2)
		else $error("two level chain counted wrongly");

	a_page_level: assert property ((lookup_res.valid && lookup_res.levels != 3'h0)
			|-> lookup_res.page_table_level == lookup_res.levels - 3'h1)
		else $error("page tables not at the lowest level");

	a_full_depth: assert property ((lookup_req.valid && tc_reg.fourth_level_index_width != 4'h0
			&& tc_reg.third_level_index_width != 4'h0 && tc_reg.second_level_index_width != 4'h0
			&& tc_reg.first_level_index_width != 4'h0)
			|=> lookup_res.levels == 3'h4 + {2'h0, $past(tc_reg.function_code_lookup_enable)})
		else $error("full depth tree counted wrongly");

	a_limit_upper: assert property ((lookup_req.valid && !tc_reg.function_code_lookup_enable
			&& !tc_reg.supervisor_root_enable && !crp_hi_reg.lower_upper)
			|=> lookup_res.limit_fault == ($past(crp_hi_reg.limit) < lookup_res.level_index[0]))
		else $error("upper limit check wrong");

	a_limit_lower: assert property ((lookup_req.valid && !tc_reg.function_code_lookup_enable
			&& !tc_reg.supervisor_root_enable && crp_hi_reg.lower_upper)
			|=> lookup_res.limit_fault == (lookup_res.level_index[0] < $past(crp_hi_reg.limit)))
		else $error("lower limit check wrong");

	a_limit_event: assert property ((lookup_res.valid && lookup_res.limit_fault)
			|-> status_reg[`EV_LIMIT])
		else $error("limit fault did not set its status bit");

	a_root_address: assert property (lookup_req.valid |=> lookup_res.root_table_address
			== (lookup_res.use_supervisor_root ? $past(srp_lo_reg) : $past(crp_lo_reg)))
		else $error("root table address from the wrong root pointer");

	a_cpu_root_default: assert property ((lookup_req.valid && !lookup_req.function_code[2])
			|=> !lookup_res.use_supervisor_root)
		else $error("supervisor root chosen for a user access");

	a_crp_lo_write: assert property ((reg_wr && reg_addr == `ADDR_CRP_LO)
			|=> crp_lo_reg == $past(reg_wdata))
		else $error("cpu root table address write did not land");

	a_srp_lo_write: assert property ((reg_wr && reg_addr == `ADDR_SRP_LO)
			|=> srp_lo_reg == $past(reg_wdata))
		else $error("supervisor root table address write did not land");

	a_desc_address: assert property ((desc_in.valid && desc_in.kind != tree_index_pkg::DESC_OTHER)
			|=> desc_out.valid && desc_out.address == $past(desc_in.word[31:2]))
		else $error("indirect descriptor address not passed on");

	a_desc_idle: assert property (!desc_in.valid
			|=> !desc_out.valid && desc_out.address == 30'h0000_0000)
		else $error("descriptor address shown without a descriptor");

	a_other_no_address: assert property ((desc_in.valid && desc_in.kind == tree_index_pkg::DESC_OTHER)
			|=> desc_out.address == 30'h0000_0000)
		else $error("unused descriptor bits leaked into the address");

	a_second_index: assert property ((lookup_req.valid && tc_reg.initial_shift == 4'h4
			&& tc_reg.first_level_index_width == 4'h5 && tc_reg.second_level_index_width == 4'h4)
			|=> lookup_res.level_index[1] == {11'h000, $past(lookup_req.logical_address[22:19])})
		else $error("second index not directly below the first");

	a_lower_indices: assert property ((lookup_req.valid && tc_reg[19:0] == 20'h4_5432)
			|=> lookup_res.level_index[2] == {12'h000, $past(lookup_req.logical_address[18:16])}
			&& lookup_res.level_index[3] == {13'h0000, $past(lookup_req.logical_address[15:14])})
		else $error("lower indices not contiguous");
endmodule

/* File: tree_index_map.svh */
// Offsets, field positions, reset values and timing counts for the translation tree index block.
// Summary of operation
// - Ignore as many top logical address bits as initial_shift gives; zero uses all 32.
// - Page size comes from page_size_field; pages equal logical space over page size.
// - With function-code lookup on, the top level is indexed by the three code bits.
// - Next level uses the topmost remaining address bits, first_level_index_width bits wide.
// - Lower widths chain; the first zero width ends the chain, later widths ignored.
// - Tables indexed by the last nonzero width are page tables.
// - The tree has at most five levels, counting the function-code level.
// - The root pointer limit field may bound the first address index.
// - translation_control holds the setting choosing the supervisor root pointer.
// - The 30-bit descriptor address is used only for short or long indirect descriptors.
// - Unused descriptor bits are ignored; software may keep its own data there.
// - Supervisor tree only when supervisor_root_enable and function_code_bit2 are both set.
// - Loading descriptor_type zero into either root pointer raises a configuration exception.
// - With function-code lookup on, lower/upper and limit fields are disregarded.
`ifndef TREE_INDEX_MAP_SVH
`define TREE_INDEX_MAP_SVH
`define ADDR_TC 8'h00
`define ADDR_CRP_HI 8'h04
`define ADDR_CRP_LO 8'h08
`define ADDR_SRP_HI 8'h0c
`define ADDR_SRP_LO 8'h10
`define ADDR_STATUS 8'h14
`define ADDR_CLEAR 8'h18
`define ADDR_ENABLE 8'h1c
`define TC_RESET 32'h0000_0000
`define RP_HI_RESET 32'h0000_0001
`define RP_LO_RESET 32'h0000_0000
`define DT_INVALID 2'h0
`define EV_CONFIG 0
`define EV_LIMIT 1
`define EV_DONE 2
`define EV_WIDTH 3
`define MAX_LEVELS 3'h5
`define LOOKUP_LATENCY 1
`endif

/* File: tree_index_pkg.sv */
// Types shared by the translation tree index block.
package tree_index_pkg;
	typedef struct packed {
		logic [5:0] spare;
		logic supervisor_root_enable;
		logic function_code_lookup_enable;
		logic [3:0] page_size_field;
		logic [3:0] initial_shift;
		logic [3:0] first_level_index_width;
		logic [3:0] second_level_index_width;
		logic [3:0] third_level_index_width;
		logic [3:0] fourth_level_index_width;
	} translation_control_s;
	typedef struct packed {
		logic lower_upper;
		logic [14:0] limit;
		logic [13:0] spare;
		logic [1:0] descriptor_type;
	} root_hi_s;
	typedef logic [14:0] index_t;
	typedef struct packed {
		logic valid;
		logic [2:0] function_code;
		logic [31:0] logical_address;
	} lookup_req_s;
	typedef struct packed {
		logic valid;
		logic use_supervisor_root;
		logic fc_level;
		logic [2:0] fc_index;
		logic [2:0] levels;
		logic [2:0] page_table_level;
		logic [3:0][14:0] level_index;
		logic [31:0] page_offset;
		logic [5:0] pages_log2;
		logic [31:0] root_table_address;
		logic limit_fault;
	} lookup_res_s;
	typedef enum logic [1:0] {
		DESC_OTHER = 2'b00,
		DESC_SHORT_INDIRECT = 2'b01,
		DESC_LONG_INDIRECT = 2'b10
	} desc_kind_e;
	typedef struct packed {
		logic valid;
		desc_kind_e kind;
		logic [31:0] word;
	} desc_in_s;
	typedef struct packed {
		logic valid;
		logic [29:0] address;
	} desc_out_s;
endpackage

/* File: table_memory_model.sv */
// Behavioural model of translation tables in external memory answering descriptor fetches.
`timescale 1ns/10ps
module table_memory_model (
	input wire logic clock, // system clock
	input wire logic rst, // synchronous reset, active high
	input wire logic fetch, // one-cycle fetch request
	input wire tree_index_pkg::desc_kind_e kind, // kind of the fetched entry
	input wire logic [1:0] slot, // table entry to fetch
	input wire logic slow, // answer after three cycles instead of one
	output tree_index_pkg::desc_in_s desc // descriptor to the block
);
	logic [31:0] table_word [4];
	logic [1:0] wait_count;
	tree_index_pkg::desc_kind_e kind_held;
	logic [1:0] slot_held;
	// Low bits hold software data, so a block that used them would show it.
	initial begin
		table_word[0] = 32'h1234_5677;
		table_word[1] = 32'hfedc_ba9b;
		table_word[2] = 32'h8000_0042;
		table_word[3] = 32'h0f0f_0f0d;
	end
	// Between answers the word keeps changing so no stale value can pass as data.
	always @(posedge clock) begin
		if (rst) begin
			desc <= '0;
			wait_count <= 2'h0;
		end else if (fetch) begin
			wait_count <= slow ? 2'h3 : 2'h1;
			kind_held <= kind;
			slot_held <= slot;
			desc.valid <= 1'b0;
			desc.word <= ~desc.word;
		end else if (wait_count == 2'h1) begin
			desc.valid <= 1'b1;
			desc.kind <= kind_held;
			desc.word <= table_word[slot_held];
			wait_count <= 2'h0;
		end else begin
			if (wait_count != 2'h0) wait_count <= wait_count - 2'h1;
			desc.valid <= 1'b0;
			desc.word <= ~desc.word;
		end
	end
endmodule

/* File: translation_tree_index_control_test.sv */
// Self-checking testbench for the translation tree index block.
`timescale 1ns/10ps
`include "tree_index_map.svh"
module translation_tree_index_control_test;
	logic clock = 0, rst = 1, reg_wr = 0, reg_rd = 0, irq, fetch = 0, slow = 0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0, reg_rdata, a;
	logic [1:0] slot = 2'h0;
	tree_index_pkg::desc_kind_e kind = tree_index_pkg::DESC_OTHER;
	tree_index_pkg::lookup_req_s lookup_req = '0;
	tree_index_pkg::lookup_res_s lookup_res;
	tree_index_pkg::desc_in_s desc_in;
	tree_index_pkg::desc_out_s desc_out;
	int mismatches = 0, compares = 0;
	always #20 clock = ~clock;
	tree_index_ctrl i_dut (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .lookup_req(lookup_req), .lookup_res(lookup_res),
		.desc_in(desc_in), .desc_out(desc_out), .irq(irq));
	table_memory_model i_mem (.clock(clock), .rst(rst), .fetch(fetch), .kind(kind), .slot(slot), .slow(slow),
		.desc(desc_in));
	task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task wr(input logic [7:0] ad, input logic [31:0] d);
		@(posedge clock);
		reg_addr <= ad;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask
	task rd(input string name, input logic [7:0] ad, input logic [31:0] exp);
		@(posedge clock);
		reg_addr <= ad;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1 chk(name, reg_rdata, exp);
	endtask
	task look(input logic [2:0] fc, input logic [31:0] ad);
		@(posedge clock);
		lookup_req <= '{1'b1, fc, ad};
		@(posedge clock);
		lookup_req.valid <= 1'b0;
		#1 chk("res valid", lookup_res.valid, 1);
	endtask
	function automatic logic [31:0] idx(input logic [31:0] ad, input int top, input int w);
		return (ad >> (top + 1 - w)) & ((32'h1 << w) - 1);
	endfunction
	task test_reset;
		rd("tc", `ADDR_TC, `TC_RESET);
		rd("crp hi", `ADDR_CRP_HI, `RP_HI_RESET);
		rd("srp hi", `ADDR_SRP_HI, `RP_HI_RESET);
		rd("crp lo", `ADDR_CRP_LO, `RP_LO_RESET);
		rd("status", `ADDR_STATUS, 32'h0);
		rd("unmapped", 8'h20, 32'h0);
		$display("test reset done");
	endtask
	task test_trap;
		wr(`ADDR_ENABLE, 32'h1);
		rd("enable", `ADDR_ENABLE, 32'h1);
		wr(`ADDR_CRP_HI, 32'h0003_0000);
		rd("crp kept", `ADDR_CRP_HI, `RP_HI_RESET);
		wr(`ADDR_SRP_HI, 32'h0);
		rd("srp kept", `ADDR_SRP_HI, `RP_HI_RESET);
		rd("trap", `ADDR_STATUS, 32'h1);
		chk("irq set", irq, 1);
		wr(`ADDR_CLEAR, 32'h1);
		rd("cleared", `ADDR_STATUS, 32'h0);
		rd("clear wo", `ADDR_CLEAR, 32'h0);
		chk("irq low", irq, 0);
		$display("test trap done");
	endtask
	task test_indices;
		a = 32'hb6d5_9abc;
		wr(`ADDR_TC, 32'h0000_4034);
		look(3'h2, a);
		chk("idx0 full", lookup_res.level_index[0], idx(a, 31, 4));
		chk("chain end", lookup_res.level_index[1], 0);
		chk("tic ignored", lookup_res.level_index[2], 0);
		chk("one level", lookup_res.levels, 1);
		chk("full pages", lookup_res.pages_log2, 32);
		wr(`ADDR_TC, 32'h00f4_5403);
		rd("tc", `ADDR_TC, 32'h00f4_5403);
		look(3'h1, a);
		chk("idx0", lookup_res.level_index[0], idx(a, 27, 5));
		chk("idx1", lookup_res.level_index[1], idx(a, 22, 4));
		chk("idx2", lookup_res.level_index[2], 0);
		chk("idx3", lookup_res.level_index[3], 0);
		chk("levels", lookup_res.levels, 2);
		chk("page lvl", lookup_res.page_table_level, 1);
		chk("pages", lookup_res.pages_log2, 13);
		chk("offset", lookup_res.page_offset, a & 32'h7fff);
		chk("fc lvl", lookup_res.fc_level, 0);
		$display("test indices done");
	endtask
	task test_limit;
		wr(`ADDR_CRP_HI, 32'h0003_0002);
		wr(`ADDR_ENABLE, 32'h2);
		look(3'h1, 32'h0f80_0000);
		chk("over", lookup_res.limit_fault, 1);
		rd("status", `ADDR_STATUS, 32'h6);
		chk("irq", irq, 1);
		wr(`ADDR_CLEAR, 32'h7);
		look(3'h1, 32'h0100_0000);
		chk("in", lookup_res.limit_fault, 0);
		wr(`ADDR_CRP_HI, 32'h8003_0002);
		look(3'h1, 32'h0100_0000);
		chk("under", lookup_res.limit_fault, 1);
		wr(`ADDR_TC, 32'h0104_5432);
		look(3'h5, 32'h0f80_0000);
		chk("fcl nolim", lookup_res.limit_fault, 0);
		chk("fc lvl", lookup_res.fc_level, 1);
		chk("fc idx", lookup_res.fc_index, 5);
		chk("levels", lookup_res.levels, 5);
		chk("page lvl", lookup_res.page_table_level, 4);
		chk("pages", lookup_res.pages_log2, 28);
		$display("test limit done");
	endtask
	task test_root;
		wr(`ADDR_CRP_LO, 32'h0000_8000);
		wr(`ADDR_SRP_LO, 32'h0000_4000);
		wr(`ADDR_SRP_HI, 32'h0000_0003);
		rd("srp load", `ADDR_SRP_HI, 32'h0000_0003);
		for (int s = 0; s < 2; s++) begin
			wr(`ADDR_TC, s ? 32'h02f4_5403 : 32'h00f4_5403);
			for (int f = 0; f < 8; f++) begin
				look(3'(f), 32'h0);
				chk("sup", lookup_res.use_supervisor_root, s & (f >> 2));
				chk("root", lookup_res.root_table_address, (s & (f >> 2)) ? 32'h4000 : 32'h8000);
			end
		end
		$display("test root done");
	endtask
	task fetch_one(input tree_index_pkg::desc_kind_e k, input logic [1:0] sl, input logic sw);
		@(posedge clock);
		fetch <= 1'b1;
		kind <= k;
		slot <= sl;
		slow <= sw;
		@(posedge clock);
		fetch <= 1'b0;
		for (int i = 0; i < 8 && desc_in.valid !== 1'b1; i++) @(posedge clock) #1;
		a = desc_in.word;
		@(posedge clock) #1;
		chk("desc valid", desc_out.valid, k != tree_index_pkg::DESC_OTHER);
		chk("desc addr", desc_out.address, (k != tree_index_pkg::DESC_OTHER) ? a >> 2 : 0);
	endtask
	task test_desc;
		fetch_one(tree_index_pkg::DESC_OTHER, 2'h0, 1'b0);
		fetch_one(tree_index_pkg::DESC_SHORT_INDIRECT, 2'h1, 1'b0);
		fetch_one(tree_index_pkg::DESC_LONG_INDIRECT, 2'h3, 1'b1);
		$display("test desc done");
	endtask
	task wrap_up;
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	initial begin
		#(40 * 5000);
		mismatches++;
		wrap_up();
	end
	initial begin
		repeat (20) @(posedge clock);
		rst <= 1'b0;
		test_reset();
		test_trap();
		test_indices();
		test_limit();
		test_root();
		test_desc();
		wrap_up();
	end
endmodule
